// ===== bdp_params.svh
// Register offsets, field positions, reset values and counts of the blanking data bank.
// Assumes the serial control port decodes sub-map addresses into 8-bit offsets.
`ifndef BDP_PARAMS_SVH
`define BDP_PARAMS_SVH
`define BDP_OFS_LINE_0 8'h75
`define BDP_OFS_LINE_1 8'h76
`define BDP_OFS_LINE_2 8'h77
`define BDP_OFS_FLAGS 8'h78
`define BDP_OFS_CAP_0 8'h79
`define BDP_OFS_CAP_1 8'h7A
`define BDP_OFS_COPY_0 8'h7D
`define BDP_OFS_COPY_1 8'h7E
`define BDP_OFS_COPY_2 8'h7F
`define BDP_OFS_OPTIONS 8'h9C
`define BDP_OFS_CLEAR 8'h78
`define BDP_OPT_CHANGE_BIT 4
`define BDP_CLR_CAP_BIT 0
`define BDP_CLR_COPY_BIT 2
`define BDP_LINE_COUNT 6
`define BDP_BYTE_RESET 8'h00
`define BDP_DEFAULT_STD 4'h0
`endif

// ===== bdp_pkg.sv
// Types shared by the blanking data bank.
// Assumes nothing beyond a SystemVerilog compiler.
package bdp_pkg;
    typedef logic [3:0] bdp_std_type;
    typedef logic [7:0] bdp_byte_type;
endpackage

// ===== bdp_copy_track.sv
// Copy info capture with optional content-change gating of the available flag.
// Assumes decoded words arrive as one-cycle strobes on the system clock.
`timescale 1ns/10ps
`include "bdp_params.svh"
module bdp_copy_track (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic copy_strobe,
    input wire logic [13:0] copy_payload_in,
    input wire logic [5:0] copy_check_in,
    input wire logic change_only,
    input wire logic reinit,
    output logic [13:0] payload,
    output logic [5:0] check,
    output logic available
);
    logic [13:0] payload_reg, payload_next;
    logic [5:0] check_reg, check_next;
    logic avail_reg, avail_next;
    logic differs;

    assign differs = (copy_payload_in != payload_reg) || (copy_check_in != check_reg);

    always_comb begin
        payload_next = payload_reg;
        check_next = check_reg;
        avail_next = avail_reg;
        if (reinit) begin
            payload_next = 14'h0000;
            check_next = 6'h00;
            avail_next = 1'b0;
        end
        if (copy_strobe) begin
            payload_next = copy_payload_in;
            check_next = copy_check_in;
            if (!change_only || differs || reinit) begin
                avail_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            payload_reg <= 14'h0000;
            check_reg <= 6'h00;
            avail_reg <= 1'b0;
        end else begin
            payload_reg <= payload_next;
            check_reg <= check_next;
            avail_reg <= avail_next;
        end
    end

    assign payload = payload_reg;
    assign check = check_reg;
    assign available = avail_reg;

    a_change_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (copy_strobe && change_only && !differs && !reinit && !avail_reg) |=> !avail_reg)
        else $error("copy flag raised for unchanged content");
    a_copy_reinit: assert property (@(posedge sys_clk) disable iff (rst)
        (reinit && !copy_strobe) |=> (!avail_reg && payload_reg == 14'h0000))
        else $error("copy reinit did not clear");
endmodule

// ===== bdp_bank.sv
// Register bank of the blanking-interval data processor.
// Assumes the serial control port gives one-cycle read and write strobes with an 8-bit offset.
`timescale 1ns/10ps
`include "bdp_params.svh"
module bdp_bank (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic manual_line_programming,
    input wire logic cap_strobe,
    input wire logic cap_even_in,
    input wire logic [7:0] cap_first_in,
    input wire logic [7:0] cap_second_in,
    input wire logic copy_strobe,
    input wire logic [13:0] copy_payload_in,
    input wire logic [5:0] copy_check_in,
    input wire logic teletext_in,
    output logic [23:0] line_std_select_field,
    output logic [23:0] line_std_default_use
);
    localparam int NLINE = `BDP_LINE_COUNT;
    bdp_pkg::bdp_byte_type line_reg [3], line_next [3];
    bdp_pkg::bdp_byte_type options_reg, options_next;
    bdp_pkg::bdp_byte_type cap0_reg, cap0_next, cap1_reg, cap1_next;
    logic cap_avail_reg, cap_avail_next, cap_even_reg, cap_even_next;
    logic ttx_reg, ttx_next;
    logic cap_reinit_reg, cap_reinit_next, copy_reinit_reg, copy_reinit_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [13:0] copy_payload;
    logic [5:0] copy_check;
    logic copy_avail;
    logic [7:0] flags;
    logic [23:0] select_out_reg;
    wire logic [23:0] select_out_next;
    logic [23:0] default_out_reg;
    wire logic [23:0] default_out_next;

    bdp_copy_track i_bdp_copy_track (
        .sys_clk(sys_clk),
        .rst(rst),
        .copy_strobe(copy_strobe),
        .copy_payload_in(copy_payload_in),
        .copy_check_in(copy_check_in),
        .change_only(options_reg[`BDP_OPT_CHANGE_BIT]),
        .reinit(copy_reinit_reg),
        .payload(copy_payload),
        .check(copy_check),
        .available(copy_avail)
    );

    genvar g;
    generate
        for (g = 0; g < NLINE; g++) begin : gen_line
            bdp_pkg::bdp_std_type sel;
            assign sel = line_reg[g / 2][(g % 2) * 4 +: 4];
            assign select_out_next[g * 4 +: 4] =
                manual_line_programming ? sel : `BDP_DEFAULT_STD;
            assign default_out_next[g * 4 +: 4] =
                manual_line_programming ? 4'h0 : 4'hF;
        end
    endgenerate

    assign flags = {ttx_reg, 4'h0, copy_avail, cap_even_reg, cap_avail_reg};

    always_comb begin
        line_next = line_reg;
        options_next = options_reg;
        cap_reinit_next = 1'b0;
        copy_reinit_next = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                `BDP_OFS_LINE_0: line_next[0] = reg_wdata;
                `BDP_OFS_LINE_1: line_next[1] = reg_wdata;
                `BDP_OFS_LINE_2: line_next[2] = reg_wdata;
                `BDP_OFS_OPTIONS: options_next = {3'h0, reg_wdata[4], 4'h0};
                `BDP_OFS_CLEAR: begin
                    cap_reinit_next = reg_wdata[`BDP_CLR_CAP_BIT];
                    copy_reinit_next = reg_wdata[`BDP_CLR_COPY_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        cap0_next = cap0_reg;
        cap1_next = cap1_reg;
        cap_avail_next = cap_avail_reg;
        cap_even_next = cap_even_reg;
        ttx_next = teletext_in;
        if (cap_reinit_reg) begin
            cap0_next = `BDP_BYTE_RESET;
            cap1_next = `BDP_BYTE_RESET;
            cap_avail_next = 1'b0;
            cap_even_next = 1'b0;
        end
        if (cap_strobe) begin
            cap0_next = cap_first_in;
            cap1_next = cap_second_in;
            cap_even_next = cap_even_in;
            cap_avail_next = 1'b1;
        end
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                `BDP_OFS_LINE_0: rdata_next = line_reg[0];
                `BDP_OFS_LINE_1: rdata_next = line_reg[1];
                `BDP_OFS_LINE_2: rdata_next = line_reg[2];
                `BDP_OFS_FLAGS: rdata_next = flags;
                `BDP_OFS_CAP_0: rdata_next = cap0_reg;
                `BDP_OFS_CAP_1: rdata_next = cap1_reg;
                `BDP_OFS_COPY_0: rdata_next = {4'h0, copy_check[5:2]};
                `BDP_OFS_COPY_1: rdata_next = {copy_check[1:0], copy_payload[13:8]};
                `BDP_OFS_COPY_2: rdata_next = copy_payload[7:0];
                `BDP_OFS_OPTIONS: rdata_next = options_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            line_reg <= '{8'h00, 8'h00, 8'h00};
            options_reg <= 8'h00;
            cap0_reg <= 8'h00;
            cap1_reg <= 8'h00;
            cap_avail_reg <= 1'b0;
            cap_even_reg <= 1'b0;
            ttx_reg <= 1'b0;
            cap_reinit_reg <= 1'b0;
            copy_reinit_reg <= 1'b0;
            rdata_reg <= 8'h00;
            select_out_reg <= 24'h000000;
            default_out_reg <= 24'hFFFFFF;
        end else begin
            line_reg <= line_next;
            options_reg <= options_next;
            cap0_reg <= cap0_next;
            cap1_reg <= cap1_next;
            cap_avail_reg <= cap_avail_next;
            cap_even_reg <= cap_even_next;
            ttx_reg <= ttx_next;
            cap_reinit_reg <= cap_reinit_next;
            copy_reinit_reg <= copy_reinit_next;
            rdata_reg <= rdata_next;
            select_out_reg <= select_out_next;
            default_out_reg <= default_out_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign line_std_select_field = select_out_reg;
    assign line_std_default_use = default_out_reg;

    a_line_write: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == 8'h75) |=> line_reg[0] == $past(reg_wdata))
        else $error("line select write lost");
    a_line_upper: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == 8'h77) |=> line_reg[2] == $past(reg_wdata))
        else $error("upper line select write lost");
    a_manual_select: assert property (@(posedge sys_clk) disable iff (rst)
        manual_line_programming |=> line_std_select_field ==
            {$past(line_reg[2]), $past(line_reg[1]), $past(line_reg[0])})
        else $error("select fields do not follow line registers");
    a_manual_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !manual_line_programming |=> line_std_select_field == 24'h000000)
        else $error("select fields active without manual mode");
    a_default_use: assert property (@(posedge sys_clk) disable iff (rst)
        !manual_line_programming |=> line_std_default_use == 24'hFFFFFF)
        else $error("default decode flag missing");
    a_manual_use: assert property (@(posedge sys_clk) disable iff (rst)
        manual_line_programming |=> line_std_default_use == 24'h000000)
        else $error("default decode flag set in manual mode");
    a_flag_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h78) |=> reg_rdata[6:3] == 4'h0)
        else $error("reserved flag bits not zero");
    a_ttx_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h78) |=> reg_rdata[7] == $past(ttx_reg))
        else $error("teletext flag readback wrong");
    a_cap_set: assert property (@(posedge sys_clk) disable iff (rst)
        cap_strobe |=> (cap_avail_reg && cap_even_reg == $past(cap_even_in)))
        else $error("caption flag not set on capture");
    a_cap_reinit: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == `BDP_OFS_CLEAR && reg_wdata[0]) ##1 !cap_strobe
            |=> (!cap_avail_reg && cap0_reg == 8'h00))
        else $error("caption reinit did not clear");
    a_copy_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == `BDP_OFS_CLEAR && reg_wdata[2]) |=> copy_reinit_reg)
        else $error("copy reinit not started");
    a_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
        cap_reinit_reg && !reg_wr |=> !cap_reinit_reg && !copy_reinit_reg)
        else $error("reinit bit stuck");
    a_cap_byte: assert property (@(posedge sys_clk) disable iff (rst)
        cap_strobe |=> (cap0_reg == $past(cap_first_in) && cap1_reg == $past(cap_second_in)))
        else $error("caption byte not captured");
    a_cap_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h7A) |=> reg_rdata == $past(cap1_reg))
        else $error("second caption byte readback wrong");
    a_cap_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!cap_strobe && !cap_reinit_reg) |=> $stable(cap1_reg))
        else $error("caption byte changed without cause");
    a_copy_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h7F) |=> reg_rdata == $past(copy_payload[7:0]))
        else $error("copy payload readback wrong");
    a_check_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h7D) |=> reg_rdata == {4'h0, $past(copy_check[5:2])})
        else $error("copy check bits readback wrong");
    a_copy_mid_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h7E) |=> reg_rdata == {$past(copy_check[1:0]), $past(copy_payload[13:8])})
        else $error("copy middle byte readback wrong");
    a_options_write: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == 8'h9C) |=> options_reg[4] == $past(reg_wdata[4]))
        else $error("content change option write lost");

    c_cap_seen: cover property (@(posedge sys_clk) cap_strobe ##1 cap_avail_reg);
    c_copy_seen: cover property (@(posedge sys_clk) copy_strobe ##1 copy_avail);
    c_cap_clear: cover property (@(posedge sys_clk) cap_avail_reg ##1 cap_reinit_reg ##1 !cap_avail_reg);
    c_manual: cover property (@(posedge sys_clk) manual_line_programming && line_reg[0] != 8'h00);
    c_copy_clear: cover property (@(posedge sys_clk) copy_avail ##1 copy_reinit_reg ##1 !copy_avail);
endmodule

// ===== bdp_bank_tb.sv
// Self-checking testbench for the blanking data register bank.
// Assumes the bank is reached by one-cycle read and write strobes on sys_clk.
`timescale 1ns/10ps
`include "bdp_params.svh"
module bdp_bank_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic manual_line_programming = 1'b0;
    logic cap_strobe = 1'b0;
    logic cap_even_in = 1'b0;
    logic [7:0] cap_first_in = 8'h00;
    logic [7:0] cap_second_in = 8'h00;
    logic copy_strobe = 1'b0;
    logic [13:0] copy_payload_in = 14'h0000;
    logic [5:0] copy_check_in = 6'h00;
    logic teletext_in = 1'b0;
    logic [23:0] line_std_select_field;
    logic [23:0] line_std_default_use;
    int num_errors = 0;
    int checked = 0;

    bdp_bank i_bdp_bank (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .manual_line_programming(manual_line_programming), .cap_strobe(cap_strobe),
        .cap_even_in(cap_even_in), .cap_first_in(cap_first_in),
        .cap_second_in(cap_second_in), .copy_strobe(copy_strobe),
        .copy_payload_in(copy_payload_in), .copy_check_in(copy_check_in),
        .teletext_in(teletext_in), .line_std_select_field(line_std_select_field),
        .line_std_default_use(line_std_default_use));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk($sformatf("register %h", a), {16'h0000, exp}, {16'h0000, reg_rdata});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic cap(input logic ev, input logic [7:0] b0, input logic [7:0] b1);
        @(negedge sys_clk);
        cap_strobe = 1'b1;
        cap_even_in = ev;
        cap_first_in = b0;
        cap_second_in = b1;
        @(negedge sys_clk);
        cap_strobe = 1'b0;
        cap_first_in = ~b0;
        cap_second_in = ~b1;
    endtask

    task automatic copy(input logic [13:0] p, input logic [5:0] c);
        @(negedge sys_clk);
        copy_strobe = 1'b1;
        copy_payload_in = p;
        copy_check_in = c;
        @(negedge sys_clk);
        copy_strobe = 1'b0;
        copy_payload_in = ~p;
        copy_check_in = ~c;
    endtask

    task automatic t_reset();
        logic [7:0] ofs [12] = '{8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7D, 8'h7E,
            8'h7F, 8'h9C, 8'h7B, 8'h80};
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        $display("reset test done");
    endtask

    task automatic t_lines();
        wr(8'h75, 8'h21);
        wr(8'h76, 8'h43);
        wr(8'h77, 8'h65);
        rd(8'h75, 8'h21);
        rd(8'h77, 8'h65);
        manual_line_programming = 1'b1;
        @(negedge sys_clk);
        chk("select field", 24'h654321, line_std_select_field);
        chk("default use", 24'h000000, line_std_default_use);
        manual_line_programming = 1'b0;
        @(negedge sys_clk);
        chk("select field", 24'h000000, line_std_select_field);
        chk("default use", 24'hFFFFFF, line_std_default_use);
        $display("line select test done");
    endtask

    task automatic t_caption();
        teletext_in = 1'b1;
        cap(1'b1, 8'h5A, 8'hC3);
        rd(8'h78, 8'h83);
        rd(8'h79, 8'h5A);
        rd(8'h7A, 8'hC3);
        wr(`BDP_OFS_CLEAR, 8'h00);
        repeat (2) @(negedge sys_clk);
        rd(8'h78, 8'h83);
        wr(`BDP_OFS_CLEAR, 8'h01);
        repeat (2) @(negedge sys_clk);
        rd(8'h78, 8'h80);
        rd(8'h79, 8'h00);
        rd(8'h7A, 8'h00);
        cap(1'b0, 8'h11, 8'h22);
        rd(8'h78, 8'h81);
        teletext_in = 1'b0;
        rd(8'h78, 8'h01);
        $display("caption test done");
    endtask

    task automatic t_copy();
        copy(14'h2A5C, 6'h2D);
        rd(8'h78, 8'h05);
        rd(8'h7D, 8'h0B);
        rd(8'h7E, 8'h6A);
        rd(8'h7F, 8'h5C);
        wr(`BDP_OFS_CLEAR, 8'h00);
        repeat (2) @(negedge sys_clk);
        rd(8'h78, 8'h05);
        rd(8'h7F, 8'h5C);
        wr(`BDP_OFS_CLEAR, 8'h04);
        repeat (2) @(negedge sys_clk);
        rd(8'h78, 8'h01);
        rd(8'h7D, 8'h00);
        rd(8'h7E, 8'h00);
        rd(8'h7F, 8'h00);
        $display("copy info test done");
    endtask

    task automatic t_change();
        wr(8'h9C, 8'hFF);
        rd(8'h9C, 8'h10);
        copy(14'h0000, 6'h00);
        rd(8'h78, 8'h01);
        copy(14'h0001, 6'h00);
        rd(8'h78, 8'h05);
        wr(8'h9C, 8'h00);
        wr(`BDP_OFS_CLEAR, 8'h04);
        repeat (2) @(negedge sys_clk);
        copy(14'h0000, 6'h00);
        rd(8'h78, 8'h05);
        $display("content change test done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_lines();
        t_caption();
        t_copy();
        t_change();
        report_and_stop();
    end
endmodule
